// >>> hdl/scd_debug_regs.sv
// Scan chain tail, CPU-to-debugger byte channel and scan port control register.
// Assumes a single-cycle CPU I/O bus on mclk and a scan tester clocking tck on its own.
`timescale 1ns/1ps

module scd_debug_regs #(
	parameter int   CHAIN_LEN      = scd_pkg::CHAIN_LEN,
	parameter logic CHANNEL_SHARED = 1'b0
) (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire logic [7:0]           busAddr,
	input  wire logic                 busIsIo,
	input  wire logic                 busWr,
	input  wire logic                 busRd,
	input  wire logic [7:0]           busWdata,
	output logic      [7:0]           busRdata_q,
	output logic                      altSel_q,
	input  wire logic                 debugAccessFuse,
	input  wire logic                 scanPortFuse,
	output logic                      scanPortEn_q,
	output logic                      sysResetReq_q,
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo_q,
	output logic                      tdoEn_q,
	input  wire logic [CHAIN_LEN-1:0] pinObs,
	output logic      [CHAIN_LEN-1:0] bscanUpd_q,
	output logic                      clockEnableCell_q
);

	// ---------------- Main clock domain signals ----------------
	logic       fuseDbg1_q, fuseDbg2_q, fuseScan1_q, fuseScan2_q;
	logic       accSync1_q, accSync2_q, rstReqSync1_q, rstReqSync2_q;
	logic       clrSync1_q, clrSync2_q, clrSync3_q;
	logic [6:0] chanData_q;
	logic       dirty_q;
	logic [7:0] ctrl_q;
	logic [2:0] armCnt_q;
	logic       armVal_q;
	logic       chanOpen, hitChan, hitCtrl, clrEvent, timedAccept;

	// ---------------- Link clock domain signals ----------------
	logic                 tRst1_q, tRst2_q, tEn1_q, tEn2_q, tHold;
	logic                 dirtyT1_q, dirtyT2_q;
	logic [6:0]           chanCopy_q;
	logic [CHAIN_LEN-1:0] pinSync1_q, pinSync2_q, drSh_q, drNext;
	logic [3:0]           ir_q, irSh_q;
	logic                 scanRst_q, accessEn_q, clrTgl_q;
	int                   drLen;
	scd_pkg::scd_tap_e    state_q, stateNext;

	// Decodes a register both as an I/O offset and as its data-space alias.
	function automatic logic regHit(input logic [7:0] addr, input logic isIo,
		input logic [7:0] ofs);
		regHit = isIo ? (addr == ofs) : (addr == ofs + scd_pkg::DATA_SPACE_OFFSET);
	endfunction

	// Address decode and channel visibility.
	assign hitChan  = regHit(busAddr, busIsIo, scd_pkg::IO_DEBUG_CHANNEL);
	assign hitCtrl  = regHit(busAddr, busIsIo, scd_pkg::IO_MCU_CONTROL);
	assign chanOpen = !CHANNEL_SHARED || (fuseDbg2_q && accSync2_q);
	assign clrEvent = clrSync2_q ^ clrSync3_q;
	assign timedAccept = (armCnt_q != 3'h0) && (busWdata[scd_pkg::BIT_PORT_OFF] == armVal_q);

	// Two-stage synchronisers for pins and link-domain levels and toggles.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			{fuseDbg1_q, fuseDbg2_q, fuseScan1_q, fuseScan2_q} <= 4'h0;
			{accSync1_q, accSync2_q, rstReqSync1_q, rstReqSync2_q} <= 4'h0;
			{clrSync1_q, clrSync2_q, clrSync3_q} <= 3'h0;
		end else begin
			fuseDbg1_q    <= debugAccessFuse;
			fuseDbg2_q    <= fuseDbg1_q;
			fuseScan1_q   <= scanPortFuse;
			fuseScan2_q   <= fuseScan1_q;
			accSync1_q    <= accessEn_q;
			accSync2_q    <= accSync1_q;
			rstReqSync1_q <= scanRst_q;
			rstReqSync2_q <= rstReqSync1_q;
			clrSync1_q    <= clrTgl_q;
			clrSync2_q    <= clrSync1_q;
			clrSync3_q    <= clrSync2_q;
		end
	end

	// Debug byte channel: a CPU write stores the low seven bits and marks them dirty.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			chanData_q <= scd_pkg::DEBUG_CHANNEL_RESET[6:0];
			dirty_q    <= 1'b0;
		end else if (busWr && hitChan && chanOpen) begin
			chanData_q <= busWdata[6:0];
			dirty_q    <= 1'b1;
		end else if (clrEvent) begin
			dirty_q <= 1'b0;
		end
	end

	// Timed sequence window for the port-disable bit.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			armCnt_q <= 3'h0;
			armVal_q <= 1'b0;
		end else if (busWr && hitCtrl && !timedAccept) begin
			armCnt_q <= scd_pkg::TIMED_WRITE_CYCLES - 3'h1;
			armVal_q <= busWdata[scd_pkg::BIT_PORT_OFF];
		end else if (busWr && hitCtrl) begin
			armCnt_q <= 3'h0;
		end else if (armCnt_q != 3'h0) begin
			armCnt_q <= armCnt_q - 3'h1;
		end
	end

	// Control and status register: disable bit, reset flag, plain storage bits.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_q <= scd_pkg::MCU_CONTROL_RESET;
		end else begin
			if (busWr && hitCtrl) begin
				ctrl_q[6:5] <= busWdata[6:5];
				ctrl_q[3:0] <= busWdata[3:0];
				if (timedAccept) begin
					ctrl_q[scd_pkg::BIT_PORT_OFF] <= armVal_q;
				end
				if (!busWdata[scd_pkg::BIT_RESET_FLAG]) begin
					ctrl_q[scd_pkg::BIT_RESET_FLAG] <= 1'b0;
				end
			end
			if (rstReqSync2_q) begin
				ctrl_q[scd_pkg::BIT_RESET_FLAG] <= 1'b1;
			end
		end
	end

	// Port enable, device reset request, and registered read data.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scanPortEn_q  <= 1'b0;
			sysResetReq_q <= 1'b0;
			busRdata_q    <= 8'h00;
			altSel_q      <= 1'b0;
		end else begin
			scanPortEn_q  <= !ctrl_q[scd_pkg::BIT_PORT_OFF] && fuseScan2_q;
			sysResetReq_q <= rstReqSync2_q;
			altSel_q      <= (busWr || busRd) && hitChan && !chanOpen;
			if (busRd && hitChan && chanOpen) begin
				busRdata_q <= {dirty_q, chanData_q};
			end else if (busRd && hitCtrl) begin
				busRdata_q <= ctrl_q;
			end else begin
				busRdata_q <= 8'h00;
			end
		end
	end

	// ---------------- Link clock domain ----------------

	// Reset and port enable reach the link domain through two flip-flops.
	always_ff @(posedge tck) begin
		tRst1_q <= rst_n;
		tRst2_q <= tRst1_q;
		tEn1_q  <= scanPortEn_q;
		tEn2_q  <= tEn1_q;
	end
	assign tHold = !tRst2_q || !tEn2_q;

	// Dirty level, channel byte and pin observations crossing into tck.
	// The byte is copied while the synchronised dirty level stands, so a link clock
	// that stops between frames cannot miss an update.
	always_ff @(posedge tck) begin
		if (!tRst2_q) begin
			{dirtyT1_q, dirtyT2_q} <= 2'h0;
			chanCopy_q <= scd_pkg::DEBUG_CHANNEL_RESET[6:0];
			pinSync1_q <= '0;
			pinSync2_q <= '0;
		end else begin
			dirtyT1_q  <= dirty_q;
			dirtyT2_q  <= dirtyT1_q;
			pinSync1_q <= pinObs;
			pinSync2_q <= pinSync1_q;
			if (dirtyT2_q) begin
				chanCopy_q <= chanData_q;
			end
		end
	end

	// Controller next state from the mode select input.
	always_comb begin
		case (state_q)
			scd_pkg::TAP_RESET:    stateNext = tms ? scd_pkg::TAP_RESET : scd_pkg::TAP_IDLE;
			scd_pkg::TAP_IDLE:     stateNext = tms ? scd_pkg::TAP_SEL_DR : scd_pkg::TAP_IDLE;
			scd_pkg::TAP_SEL_DR:   stateNext = tms ? scd_pkg::TAP_SEL_IR : scd_pkg::TAP_CAP_DR;
			scd_pkg::TAP_CAP_DR:   stateNext = tms ? scd_pkg::TAP_EXIT1_DR : scd_pkg::TAP_SHIFT_DR;
			scd_pkg::TAP_SHIFT_DR: stateNext = tms ? scd_pkg::TAP_EXIT1_DR : scd_pkg::TAP_SHIFT_DR;
			scd_pkg::TAP_EXIT1_DR: stateNext = tms ? scd_pkg::TAP_UPD_DR : scd_pkg::TAP_PAUSE_DR;
			scd_pkg::TAP_PAUSE_DR: stateNext = tms ? scd_pkg::TAP_EXIT2_DR : scd_pkg::TAP_PAUSE_DR;
			scd_pkg::TAP_EXIT2_DR: stateNext = tms ? scd_pkg::TAP_UPD_DR : scd_pkg::TAP_SHIFT_DR;
			scd_pkg::TAP_UPD_DR:   stateNext = tms ? scd_pkg::TAP_SEL_DR : scd_pkg::TAP_IDLE;
			scd_pkg::TAP_SEL_IR:   stateNext = tms ? scd_pkg::TAP_RESET : scd_pkg::TAP_CAP_IR;
			scd_pkg::TAP_CAP_IR:   stateNext = tms ? scd_pkg::TAP_EXIT1_IR : scd_pkg::TAP_SHIFT_IR;
			scd_pkg::TAP_SHIFT_IR: stateNext = tms ? scd_pkg::TAP_EXIT1_IR : scd_pkg::TAP_SHIFT_IR;
			scd_pkg::TAP_EXIT1_IR: stateNext = tms ? scd_pkg::TAP_UPD_IR : scd_pkg::TAP_PAUSE_IR;
			scd_pkg::TAP_PAUSE_IR: stateNext = tms ? scd_pkg::TAP_EXIT2_IR : scd_pkg::TAP_PAUSE_IR;
			scd_pkg::TAP_EXIT2_IR: stateNext = tms ? scd_pkg::TAP_UPD_IR : scd_pkg::TAP_SHIFT_IR;
			scd_pkg::TAP_UPD_IR:   stateNext = tms ? scd_pkg::TAP_SEL_DR : scd_pkg::TAP_IDLE;
			default:               stateNext = scd_pkg::TAP_RESET;
		endcase
	end

	// Selected data register length, and the shifted value: test data in enters at
	// the top of the selected register so bit 0 leaves first and is filled last.
	always_comb begin
		case (ir_q)
			scd_pkg::INS_EXTEST, scd_pkg::INS_SAMPLE: drLen = CHAIN_LEN;
			scd_pkg::INS_CHAN_READ:                   drLen = 8;
			default:                                  drLen = 1;
		endcase
		for (int i = 0; i < CHAIN_LEN; i++) begin
			if (i == drLen - 1) begin
				drNext[i] = tdi;
			end else if (i < drLen - 1) begin
				drNext[i] = drSh_q[i + 1];
			end else begin
				drNext[i] = drSh_q[i];
			end
		end
	end

	// Controller state and instruction path.
	always_ff @(posedge tck) begin
		if (tHold) begin
			state_q <= scd_pkg::TAP_RESET;
			ir_q    <= scd_pkg::INS_BYPASS;
			irSh_q  <= scd_pkg::IR_CAPTURE;
		end else begin
			state_q <= stateNext;
			case (state_q)
				scd_pkg::TAP_RESET:    ir_q   <= scd_pkg::INS_BYPASS;
				scd_pkg::TAP_CAP_IR:   irSh_q <= scd_pkg::IR_CAPTURE;
				scd_pkg::TAP_SHIFT_IR: irSh_q <= {tdi, irSh_q[3:1]};
				scd_pkg::TAP_UPD_IR:   ir_q   <= irSh_q;
				default:               ir_q   <= ir_q;
			endcase
		end
	end

	// Data path: capture, shift, and update of the selected register.
	always_ff @(posedge tck) begin
		if (tHold) begin
			drSh_q     <= '0;
			bscanUpd_q <= '0;
			scanRst_q  <= 1'b0;
			accessEn_q <= 1'b0;
			clrTgl_q   <= 1'b0;
		end else if (state_q == scd_pkg::TAP_RESET) begin
			scanRst_q  <= 1'b0;
		end else if (state_q == scd_pkg::TAP_CAP_DR) begin
			case (ir_q)
				scd_pkg::INS_EXTEST, scd_pkg::INS_SAMPLE: drSh_q <= pinSync2_q;
				scd_pkg::INS_CHAN_READ: drSh_q <= {{(CHAIN_LEN-8){1'b0}}, dirtyT2_q, chanCopy_q};
				scd_pkg::INS_ACCESS_EN:  drSh_q <= {{(CHAIN_LEN-1){1'b0}}, accessEn_q};
				scd_pkg::INS_SCAN_RESET: drSh_q <= {{(CHAIN_LEN-1){1'b0}}, scanRst_q};
				default:                 drSh_q <= '0;
			endcase
		end else if (state_q == scd_pkg::TAP_SHIFT_DR) begin
			drSh_q <= drNext;
		end else if (state_q == scd_pkg::TAP_UPD_DR) begin
			case (ir_q)
				scd_pkg::INS_EXTEST, scd_pkg::INS_SAMPLE: bscanUpd_q <= drSh_q;
				scd_pkg::INS_CHAN_READ:  clrTgl_q   <= !clrTgl_q;
				scd_pkg::INS_ACCESS_EN:  accessEn_q <= drSh_q[0];
				scd_pkg::INS_SCAN_RESET: scanRst_q  <= drSh_q[0];
				default:                 scanRst_q  <= scanRst_q;
			endcase
		end
	end

	// Clock enable cell output taken from its fixed chain position.
	always_ff @(posedge tck) begin
		if (tHold) begin
			clockEnableCell_q <= 1'b1;
		end else if (state_q == scd_pkg::TAP_UPD_DR && ir_q == scd_pkg::INS_EXTEST) begin
			clockEnableCell_q <= drSh_q[scd_pkg::CELL_CLOCK_ENABLE];
		end
	end

	// Test data out changes on the falling edge and is driven only while shifting.
	always_ff @(negedge tck) begin
		if (!tRst2_q) begin
			tdo_q   <= 1'b0;
			tdoEn_q <= 1'b0;
		end else begin
			tdo_q   <= (state_q == scd_pkg::TAP_SHIFT_IR) ? irSh_q[0] : drSh_q[0];
			tdoEn_q <= (state_q == scd_pkg::TAP_SHIFT_IR) || (state_q == scd_pkg::TAP_SHIFT_DR);
		end
	end

	// ---------------- Checks ----------------
	sequence s_ctrlWrite(logic v);
		busWr && hitCtrl && busWdata[scd_pkg::BIT_PORT_OFF] == v;
	endsequence

	// An arming write of one while no window is open.
	sequence s_armOne;
		busWr && hitCtrl && busWdata[scd_pkg::BIT_PORT_OFF] && armCnt_q == 3'h0;
	endsequence

	// A cycle with no control register write, so the window is left alone.
	sequence s_noCtrlWrite;
		!(busWr && hitCtrl);
	endsequence

	property p_dirtySet;
		@(posedge mclk) disable iff (!rst_n)
		busWr && hitChan && chanOpen |=> dirty_q && chanData_q == $past(busWdata[6:0]);
	endproperty
	a_dirtySet: assert property (p_dirtySet) else $error("dirty not set by write");

	property p_chanRead;
		@(posedge mclk) disable iff (!rst_n)
		busRd && hitChan && chanOpen |=> busRdata_q == {$past(dirty_q), $past(chanData_q)};
	endproperty
	a_chanRead: assert property (p_chanRead) else $error("channel read data wrong");

	property p_dirtyClear;
		@(posedge mclk) disable iff (!rst_n)
		clrEvent && !(busWr && hitChan && chanOpen) |=> !dirty_q;
	endproperty
	a_dirtyClear: assert property (p_dirtyClear) else $error("dirty not cleared");

	property p_shared;
		@(posedge mclk) disable iff (!rst_n)
		busRd && hitChan && !chanOpen |=> altSel_q && busRdata_q == 8'h00;
	endproperty
	a_shared: assert property (p_shared) else $error("closed channel not diverted");

	property p_portEn;
		@(posedge mclk) disable iff (!rst_n)
		##1 scanPortEn_q == (!$past(ctrl_q[scd_pkg::BIT_PORT_OFF]) && $past(fuseScan2_q));
	endproperty
	a_portEn: assert property (p_portEn) else $error("port enable mismatch");

	property p_singleWrite;
		@(posedge mclk) disable iff (!rst_n)
		busWr && hitCtrl && armCnt_q == 3'h0 |=> $stable(ctrl_q[scd_pkg::BIT_PORT_OFF]);
	endproperty
	a_singleWrite: assert property (p_singleWrite) else $error("lone write changed bit");

	property p_timedPair;
		@(posedge mclk) disable iff (!rst_n)
		s_armOne ##1 s_noCtrlWrite ##1 s_ctrlWrite(1'b1)
		|=> ctrl_q[scd_pkg::BIT_PORT_OFF];
	endproperty
	a_timedPair: assert property (p_timedPair) else $error("timed pair ignored");

	property p_flagSet;
		@(posedge mclk) disable iff (!rst_n)
		rstReqSync2_q |=> ctrl_q[scd_pkg::BIT_RESET_FLAG];
	endproperty
	a_flagSet: assert property (p_flagSet) else $error("reset flag not set");

	property p_flagClear;
		@(posedge mclk) disable iff (!rst_n)
		busWr && hitCtrl && !busWdata[scd_pkg::BIT_RESET_FLAG] && !rstReqSync2_q
		|=> !ctrl_q[scd_pkg::BIT_RESET_FLAG];
	endproperty
	a_flagClear: assert property (p_flagClear) else $error("reset flag not cleared");

	property p_dataSpace;
		@(posedge mclk) disable iff (!rst_n)
		busRd && !busIsIo && busAddr == scd_pkg::IO_MCU_CONTROL + scd_pkg::DATA_SPACE_OFFSET
		|=> busRdata_q == $past(ctrl_q);
	endproperty
	a_dataSpace: assert property (p_dataSpace) else $error("data-space alias wrong");

	property p_clkCell;
		@(posedge tck) disable iff (tHold)
		state_q == scd_pkg::TAP_UPD_DR && ir_q == scd_pkg::INS_EXTEST
		|=> clockEnableCell_q == $past(drSh_q[scd_pkg::CELL_CLOCK_ENABLE]);
	endproperty
	a_clkCell: assert property (p_clkCell) else $error("clock enable cell wrong");

	property p_shiftIn;
		@(posedge tck) disable iff (tHold)
		state_q == scd_pkg::TAP_SHIFT_DR && drLen == 1 |=> drSh_q[0] == $past(tdi);
	endproperty
	a_shiftIn: assert property (p_shiftIn) else $error("shift input wrong");

endmodule // scd_debug_regs

// >>> common/scd_pkg.sv
// Constants shared by the scan and debug channel register block.
// Assumes an 8-bit CPU I/O bus on the main clock and a scan port on its own clock.
package scd_pkg;

	// CPU register map: I/O offsets, and the shift that data-space accesses add.
	localparam logic [7:0] IO_DEBUG_CHANNEL   = 8'h22;
	localparam logic [7:0] IO_MCU_CONTROL     = 8'h34;
	localparam logic [7:0] DATA_SPACE_OFFSET  = 8'h20;

	// Reset values.
	localparam logic [7:0] DEBUG_CHANNEL_RESET = 8'h20;
	localparam logic [7:0] MCU_CONTROL_RESET   = 8'h20;

	// Field positions.
	localparam int BIT_DIRTY      = 7;
	localparam int BIT_PORT_OFF   = 7;
	localparam int BIT_RESET_FLAG = 4;

	// The second write of the port-disable sequence must land fewer than this many CPU cycles after the first.
	localparam logic [2:0] TIMED_WRITE_CYCLES = 3'h4;

	// Scan chain tail length and fixed cell positions.
	localparam int CHAIN_LEN          = 104;
	localparam int CELL_CLOCK_ENABLE  = 102;
	localparam int CELL_RESET_OBSERVE = 103;

	// Instruction register width, capture pattern and instruction codes.
	localparam int         IR_WIDTH        = 4;
	localparam logic [3:0] IR_CAPTURE      = 4'h1;
	localparam logic [3:0] INS_EXTEST      = 4'h0;
	localparam logic [3:0] INS_SAMPLE      = 4'h2;
	localparam logic [3:0] INS_CHAN_READ   = 4'h8;
	localparam logic [3:0] INS_ACCESS_EN   = 4'h9;
	localparam logic [3:0] INS_SCAN_RESET  = 4'hC;
	localparam logic [3:0] INS_BYPASS      = 4'hF;

	// Test access port controller states.
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
		TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} scd_tap_e;

endpackage

// >>> verif/scd_scan_tester.sv
// Scan tester model: drives tck, tms and tdi, and samples tdo.
// Assumes the block samples tms and tdi on rising tck and moves tdo on falling tck.
`timescale 1ns/1ps
module scd_scan_tester (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// The link clock stands low between frames.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One tck period; inputs move after the falling edge, tdo is taken at the rising edge.
	task automatic pulse(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#32;
		o = tdo;
		tck = 1'b1;
		#32;
		tck = 1'b0;
	endtask

	// Six ones on tms reach Test-Logic-Reset, then park in Run-Test/Idle.
	task automatic reset_tap();
		logic o;
		repeat (6) pulse(1'b1, 1'b0, o);
		pulse(1'b0, 1'b0, o);
	endtask

	// Scans n bits through the instruction or data path from Run-Test/Idle and back.
	task automatic shift(input logic isIr, input int n, input logic [127:0] din,
		output logic [127:0] dout);
		logic o;
		dout = '0;
		pulse(1'b1, tdi, o);
		if (isIr) begin
			pulse(1'b1, tdi, o);
		end
		pulse(1'b0, tdi, o);
		pulse(1'b0, tdi, o);
		for (int i = 0; i < n; i++) begin
			pulse(i == n - 1, din[i], o); // Bit 0 goes first, unused cells get zeros.
			dout[i] = o;
		end
		pulse(1'b1, ~tdi, o); // Update-DR also marks a channel byte as taken.
		pulse(1'b0, ~tdi, o);
		tdi = ~tdi; // A released data line keeps moving, so no stale level is trusted.
	endtask
endmodule // scd_scan_tester

// >>> verif/tb.sv
// Self-checking bench for the scan and debug channel register block.
// Assumes the scan tester model makes the link clock; the CPU bus is driven here.
`timescale 1ns/1ps
module tb;
	localparam int CL = scd_pkg::CHAIN_LEN;
	logic          mclk, rst_n, busIsIo, busWr, busRd, altSel_q, rdLate, altSel2, shOpen;
	logic          debugAccessFuse, scanPortFuse, scanPortEn_q, sysResetReq_q;
	logic          tck, tms, tdi, tdo_q, tdoEn_q, clockEnableCell_q;
	logic [7:0]    busAddr, busWdata, busRdata_q, busRdata2, d;
	logic [CL-1:0] pinObs, bscanUpd_q;
	logic [7:0]    expQ[$];
	logic [8:0]    altQ[$];
	logic [31:0]   rnd;
	logic [127:0]  v, pv;
	int            fails, cmpCount;

	scd_debug_regs dut_u (
		.mclk(mclk), .rst_n(rst_n), .busAddr(busAddr), .busIsIo(busIsIo), .busWr(busWr),
		.busRd(busRd), .busWdata(busWdata), .busRdata_q(busRdata_q), .altSel_q(altSel_q),
		.debugAccessFuse(debugAccessFuse), .scanPortFuse(scanPortFuse),
		.scanPortEn_q(scanPortEn_q), .sysResetReq_q(sysResetReq_q), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo_q(tdo_q), .tdoEn_q(tdoEn_q), .pinObs(pinObs),
		.bscanUpd_q(bscanUpd_q), .clockEnableCell_q(clockEnableCell_q)
	);
	// Second copy with the channel behind a shared location, closed until access is enabled.
	scd_debug_regs #(.CHANNEL_SHARED(1'b1)) dut2_u (
		.mclk(mclk), .rst_n(rst_n), .busAddr(busAddr), .busIsIo(busIsIo), .busWr(busWr),
		.busRd(busRd), .busWdata(busWdata), .busRdata_q(busRdata2), .altSel_q(altSel2),
		.debugAccessFuse(debugAccessFuse), .scanPortFuse(scanPortFuse),
		.scanPortEn_q(), .sysResetReq_q(), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo_q(), .tdoEn_q(), .pinObs(pinObs),
		.bscanUpd_q(), .clockEnableCell_q()
	);
	// A released test data output shows the inverse of its last level, so no stale bit passes.
	scd_scan_tester tester_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoEn_q ? tdo_q : ~tdo_q));

	// Main clock, 25 ns period.
	always #12.5 mclk = ~mclk;

	// Pseudo-random source for data bytes and pin patterns.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Shared comparison; a mismatch is reported at once.
	task automatic checkVec(input logic [127:0] got, input logic [127:0] exp);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask

	// Read data against the oldest queued note.
	task automatic checkRd(input logic [7:0] got);
		logic [7:0] exp;
		exp = (expQ.size() != 0) ? expQ.pop_front() : 8'hxx;
		checkVec({120'h0, got}, {120'h0, exp});
	endtask

	// Diversion flag and read data of the shared-location copy against its oldest note.
	task automatic checkAlt(input logic [8:0] got);
		logic [8:0] exp;
		exp = (altQ.size() != 0) ? altQ.pop_front() : 'x;
		checkVec({119'h0, got}, {119'h0, exp});
	endtask

	// One bus cycle set up at the falling edge; a read leaves its expected byte in the queue.
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic io,
		input logic [7:0] dat, input logic [7:0] e);
		@(negedge mclk);
		busWr = w;
		busRd = r;
		busAddr = a;
		busIsIo = io;
		busWdata = dat;
		if (r) begin
			expQ.push_back(e);
			altQ.push_back((!shOpen && a == (io ? 8'h22 : 8'h42)) ? 9'h100 : {1'b0, e});
		end
	endtask

	task automatic idle(input int n);
		repeat (n) op(1'b0, 1'b0, 8'h00, 1'b1, 8'h00, 8'h00);
	endtask

	// Bounded waits for the slow levels that cross between the clocks.
	task automatic waitEn(input logic val);
		for (int i = 0; i < 40 && scanPortEn_q !== val; i++) begin
			@(negedge mclk);
		end
	endtask

	task automatic waitRst(input logic val);
		for (int i = 0; i < 40 && sysResetReq_q !== val; i++) begin
			@(negedge mclk);
		end
	endtask

	task automatic final_report();
		if (fails == 0 && cmpCount > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Each read answer is due one cycle after its strobe and is checked at the falling edge.
	always @(posedge mclk) rdLate <= busRd;
	always @(negedge mclk) begin
		if (rdLate === 1'b1) begin
			checkRd(busRdata_q);
			checkVec(altSel_q, 1'b0);
			checkAlt({altSel2, busRdata2});
		end
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#200000;
		fails++;
		final_report();
	end

	// Main sequence.
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{busWr, busRd, busAddr, busWdata} = '0;
		busIsIo = 1'b1;
		debugAccessFuse = 1'b1;
		scanPortFuse = 1'b1;
		pinObs = '0;
		shOpen = 1'b0;
		rnd = 32'h9e93_4f8e;
		fails = 0;
		cmpCount = 0;
		fork
			begin
				repeat (5) @(negedge mclk);
				rst_n = 1'b1;
			end
			tester_u.reset_tap();
		join
		waitEn(1'b1);
		checkVec(scanPortEn_q, 1'b1);
		tester_u.reset_tap();
		// Reset values, the data-space alias and an unmapped location.
		op(1'b0, 1'b1, 8'h22, 1'b1, 8'h00, 8'h20);
		op(1'b0, 1'b1, 8'h54, 1'b0, 8'h00, 8'h20);
		op(1'b0, 1'b1, 8'h23, 1'b1, 8'h00, 8'h00);
		// Random bytes written and read straight back with the dirty flag up.
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			d = rnd[7:0];
			op(1'b1, 1'b0, 8'h22, 1'b1, d, 8'h00);
			op(1'b0, 1'b1, 8'h42, 1'b0, 8'h00, {1'b1, d[6:0]});
		end
		idle(20);
		// The debugger takes the byte, lowest bit first, and the flag then reads clear.
		tester_u.shift(1'b1, 4, 128'(scd_pkg::INS_CHAN_READ), v);
		checkVec(v, 128'(scd_pkg::IR_CAPTURE));
		tester_u.shift(1'b0, 8, '0, v);
		checkVec(v, {120'h0, 1'b1, d[6:0]});
		idle(10);
		op(1'b0, 1'b1, 8'h22, 1'b1, 8'h00, {1'b0, d[6:0]});
		// Writes four cycles apart are both lone writes and leave the disable bit alone.
		op(1'b1, 1'b0, 8'h34, 1'b1, 8'ha0, 8'h00);
		idle(3);
		op(1'b1, 1'b0, 8'h34, 1'b1, 8'ha0, 8'h00);
		idle(6);
		op(1'b0, 1'b1, 8'h34, 1'b1, 8'h00, 8'h20);
		// A pair two cycles apart through the data space sets it and shuts the port.
		op(1'b1, 1'b0, 8'h54, 1'b0, 8'ha0, 8'h00);
		idle(1);
		op(1'b1, 1'b0, 8'h54, 1'b0, 8'ha0, 8'h00);
		idle(1);
		op(1'b0, 1'b1, 8'h34, 1'b1, 8'h00, 8'ha0);
		idle(1);
		waitEn(1'b0);
		checkVec(scanPortEn_q, 1'b0);
		// A write of the other value restarts the window, so the last write stands alone.
		op(1'b1, 1'b0, 8'h34, 1'b1, 8'h20, 8'h00);
		op(1'b1, 1'b0, 8'h34, 1'b1, 8'ha0, 8'h00);
		idle(1);
		op(1'b1, 1'b0, 8'h34, 1'b1, 8'h20, 8'h00);
		idle(6);
		op(1'b0, 1'b1, 8'h34, 1'b1, 8'h00, 8'ha0);
		op(1'b1, 1'b0, 8'h34, 1'b1, 8'h20, 8'h00);
		op(1'b1, 1'b0, 8'h34, 1'b1, 8'h20, 8'h00);
		idle(1);
		op(1'b0, 1'b1, 8'h34, 1'b1, 8'h00, 8'h20);
		idle(1);
		waitEn(1'b1);
		checkVec(scanPortEn_q, 1'b1);
		// An unprogrammed port fuse shuts the port whatever the disable bit says.
		scanPortFuse = 1'b0;
		waitEn(1'b0);
		checkVec(scanPortEn_q, 1'b0);
		@(negedge mclk);
		scanPortFuse = 1'b1;
		waitEn(1'b1);
		tester_u.reset_tap();
		// A one in the reset register requests a device reset and records its source.
		tester_u.shift(1'b1, 4, 128'(scd_pkg::INS_SCAN_RESET), v);
		tester_u.shift(1'b0, 1, 128'h1, v);
		waitRst(1'b1);
		checkVec(sysResetReq_q, 1'b1);
		idle(2);
		op(1'b0, 1'b1, 8'h34, 1'b1, 8'h00, 8'h30);
		idle(1);
		tester_u.reset_tap();
		waitRst(1'b0);
		checkVec(sysResetReq_q, 1'b0);
		op(1'b0, 1'b1, 8'h34, 1'b1, 8'h00, 8'h30);
		op(1'b1, 1'b0, 8'h34, 1'b1, 8'h20, 8'h00);
		op(1'b0, 1'b1, 8'h34, 1'b1, 8'h00, 8'h20);
		idle(1);
		// Two random pin patterns captured, shifted out and shifted back in, with cell 102 clear and then set.
		for (int k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			pv = {4{rnd}};
			pv[scd_pkg::CELL_CLOCK_ENABLE] = k[0];
			pv[127:CL] = '0;
			@(negedge mclk);
			pinObs = pv[CL-1:0];
			tester_u.shift(1'b1, 4, 128'(scd_pkg::INS_EXTEST), v);
			tester_u.shift(1'b0, CL, pv, v);
			checkVec(v, pv);
			checkVec(bscanUpd_q, pv[CL-1:0]);
			checkVec(clockEnableCell_q, k[0]);
		end
		// Enabling access opens the shared location to the channel as well.
		tester_u.shift(1'b1, 4, 128'(scd_pkg::INS_ACCESS_EN), v);
		tester_u.shift(1'b0, 1, 128'h1, v);
		idle(4);
		shOpen = 1'b1;
		op(1'b1, 1'b0, 8'h22, 1'b1, d, 8'h00);
		op(1'b0, 1'b1, 8'h22, 1'b1, 8'h00, {1'b1, d[6:0]});
		idle(2);
		final_report();
	end
endmodule // tb
